// ---- include/cdd_pkg.sv ----
// cdd_pkg: shared constants and types for the cascaded channel divider block
package cdd_pkg;
   // register word indices; the byte address is four times the index
   localparam logic [9:0] IDX_A1_RATIO   = 10'h199;
   localparam logic [9:0] IDX_A_PHASE    = 10'h19A;
   localparam logic [9:0] IDX_A2_RATIO   = 10'h19B;
   localparam logic [9:0] IDX_A_START    = 10'h19C;
   localparam logic [9:0] IDX_A_DCC      = 10'h19D;
   localparam logic [9:0] IDX_B1_RATIO   = 10'h19E;
   localparam logic [9:0] IDX_B_PHASE    = 10'h19F;
   localparam logic [9:0] IDX_B2_RATIO   = 10'h1A0;
   localparam logic [9:0] IDX_B_START    = 10'h1A1;
   localparam logic [9:0] IDX_B_DCC      = 10'h1A2;
   localparam logic [9:0] IDX_CTRL       = 10'h1B0;
   localparam logic [9:0] IDX_STATUS     = 10'h1B1;
   // field positions
   localparam int LOW_MSB   = 7;
   localparam int LOW_LSB   = 4;
   localparam int HIGH_MSB  = 3;
   localparam int HIGH_LSB  = 0;
   localparam int START1_BIT = 0;
   localparam int START2_BIT = 1;
   localparam int BYP1_BIT  = 4;
   localparam int BYP2_BIT  = 5;
   localparam int DCC_DISABLE_BIT = 0;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_VCO_DIV3_BIT = 1;
   // phase value weights
   localparam logic [4:0] PHASE_START_WEIGHT = 5'h10;
   localparam logic [4:0] PHASE_SPLIT     = 5'h10;
   // reset values
   localparam logic [7:0] RATIO_RESET = 8'h00;
   localparam logic [7:0] PHASE_RESET = 8'h00;
   localparam logic [7:0] START_RESET = 8'h00;
   localparam logic [7:0] DCC_RESET   = 8'h00;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   // one stage's settings
   typedef struct packed {
      logic [3:0] low_count;
      logic [3:0] high_count;
      logic       initial_level_bit;
      logic [3:0] coarse_delay_field;
      logic       bypass;
      logic       duty_correction_disable;
   } cdd_stage_cfg_t;
endpackage : cdd_pkg

// ---- core/cdd_stage.sv ----
// cdd_stage: one divider stage with coarse delay and duty correction
`timescale 1ns/1ps
module cdd_stage
   import cdd_pkg::*;
(
   // clock and control
   input  wire logic           MCLK,
   input  wire logic           RST,
   input  wire logic           run,
   input  wire logic           clk_en_in,
   input  wire logic           level_in,
   input  cdd_stage_cfg_t      cfg,
   // outputs
   output logic                level_out,
   output logic                edge_out
);
   logic [4:0] phase;
   logic [5:0] cnt;
   logic       started;
   logic [5:0] delay_cycles;
   logic       odd_corr;
   logic       stretch;

   // phase value 0..31 from start bit and offset field
   assign phase = cfg.initial_level_bit ? (PHASE_START_WEIGHT + {1'b0, cfg.coarse_delay_field})
                                        : {1'b0, cfg.coarse_delay_field}; // [RULE_12]
   // below 16 the phase counts directly, from 16 up low count plus one is added
   assign delay_cycles = (phase < PHASE_SPLIT) ? {1'b0, phase}
                       : 6'(phase - PHASE_SPLIT) + 6'(cfg.low_count) + 6'h01; // [RULE_13] [RULE_14] [RULE_15] [RULE_16]
   // odd stage with low count one above high count and correction ends its high time on the input's fall
   assign odd_corr = !cfg.duty_correction_disable && (cfg.low_count == 4'(cfg.high_count + 4'h1));

   // counter: low phase then high phase, advanced only on input ticks
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cnt       <= 6'h00;
         started   <= 1'b0;
         stretch   <= 1'b0;
         level_out <= 1'b0;
         edge_out  <= 1'b0;
      end else if (!run) begin
         cnt       <= 6'h00;
         started   <= (delay_cycles == 6'h00); // zero phase spends no tick on delay [RULE_13]
         stretch   <= 1'b0;
         level_out <= 1'b0;
         edge_out  <= 1'b0;
      end else if (cfg.bypass) begin
         level_out <= level_in; // divide by one [RULE_18]
         edge_out  <= clk_en_in;
         stretch   <= 1'b0;
      end else begin
         edge_out <= 1'b0;
         if (stretch) begin
            // high ends on the input fall, so odd ratios gain the input's high time
            if (!level_in) begin // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_07]
               level_out <= 1'b0;
               edge_out  <= 1'b1;
               stretch   <= 1'b0;
            end
         end else if (clk_en_in) begin
            if (!started) begin
               if (cnt + 6'h01 >= delay_cycles) begin
                  started <= 1'b1;
                  cnt     <= 6'h00;
               end else begin
                  cnt <= cnt + 6'h01;
               end
            end else if (!level_out) begin
               if (cnt == 6'(cfg.low_count)) begin // low for M+1 ticks [RULE_17]
                  level_out <= 1'b1;
                  edge_out  <= 1'b1;
                  cnt       <= 6'h00;
               end else begin
                  cnt <= cnt + 6'h01;
               end
            end else if (cnt == 6'(cfg.high_count)) begin // high for N+1 ticks [RULE_17]
               cnt <= 6'h00;
               if (odd_corr) begin
                  stretch <= 1'b1; // ticks are ignored until the input fall ends the stretch; low count starts after it [RULE_03]
               end else begin
                  level_out <= 1'b0;
                  edge_out  <= 1'b1;
               end
            end else begin
               cnt <= cnt + 6'h01;
            end
         end
      end
   end
endmodule : cdd_stage

// ---- core/cdd_channel.sv ----
// cdd_channel: two cascaded two-stage channel dividers with Avalon-MM registers
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
// What this block does
// RULE_01: fifty percent input gives fifty percent output
// RULE_02: both bypassed: duty follows vco odd divider
// RULE_03: any even divide gives fifty percent
// RULE_04: odd first stage with vco divide formula
// RULE_05: both stages odd with vco divide formula
// RULE_06: no vco divider: bypass passes input duty
// RULE_07: no vco divider: odd stage duty formulas
// RULE_08: software programs counts to suit correction
// RULE_09: second divider start and offset fields
// RULE_10: first divider start and offset fields
// RULE_11: low count upper nibble, high lower
// RULE_12: phase equals sixteen start plus offset
// RULE_13: both phases small: direct period counts
// RULE_14: second phase large adds low count
// RULE_15: first phase large adds low count
// RULE_16: both large: each adds low count
// RULE_17: low M+1, high N+1 input cycles
// RULE_18: bypassed stage divides by one, product otherwise
// RULE_19: second stage clocked by first stage output
module cdd_channel
   import cdd_pkg::*;
(
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST,
   // divider input clock, asynchronous to MCLK
   input  wire logic        DIV_CLK_IN,
   // avalon-mm slave, word addressed
   input  wire logic [9:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // channel outputs
   output logic             DIFFERENTIAL_OUTPUT_FIRST,
   output logic             DIFFERENTIAL_OUTPUT_LAST
);
   // register file
   logic [7:0] a1_ratio, a_phase, a2_ratio, a_start, a_dcc;
   logic [7:0] b1_ratio, b_phase, b2_ratio, b_start, b_dcc;
   logic [7:0] ctrl;
   logic       ack;
   logic       clk_s1, clk_s2, clk_prev;
   logic       in_tick;
   cdd_stage_cfg_t cfg_a1, cfg_a2, cfg_b1, cfg_b2;
   logic       a1_lvl, a1_edge, a2_lvl, a2_edge;
   logic       b1_lvl, b1_edge, b2_lvl, b2_edge;
   logic       a2_tick, b2_tick;
   logic       wr_lane0;

   // two-flop synchroniser for the divider input clock
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
      end else begin
         clk_s1 <= DIV_CLK_IN;
         clk_s2 <= clk_s1;
      end
   end

   // rising-edge detect on the synchronised clock
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         clk_prev <= 1'b0;
      end else begin
         clk_prev <= clk_s2;
      end
   end
   assign in_tick = clk_s2 && !clk_prev;

   // only byte lane 0 carries data; upper lanes ignored
   assign wr_lane0 = AVS_WRITE && AVS_BYTEENABLE[0] && ack;

   // register writes land at the edge where waitrequest is seen low
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         a1_ratio <= RATIO_RESET;
         a_phase  <= PHASE_RESET;
         a2_ratio <= RATIO_RESET;
         a_start  <= START_RESET;
         a_dcc    <= DCC_RESET;
         b1_ratio <= RATIO_RESET;
         b_phase  <= PHASE_RESET;
         b2_ratio <= RATIO_RESET;
         b_start  <= START_RESET;
         b_dcc    <= DCC_RESET;
         ctrl     <= CTRL_RESET;
      end else if (wr_lane0) begin
         if (AVS_ADDRESS == IDX_A1_RATIO) begin
            a1_ratio <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_A_PHASE) begin
            a_phase <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_A2_RATIO) begin
            a2_ratio <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_A_START) begin
            a_start <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_A_DCC) begin
            a_dcc <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_B1_RATIO) begin
            b1_ratio <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_B_PHASE) begin
            b_phase <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_B2_RATIO) begin
            b2_ratio <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_B_START) begin
            b_start <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_B_DCC) begin
            b_dcc <= AVS_WRITEDATA[7:0];
         end else if (AVS_ADDRESS == IDX_CTRL) begin
            ctrl <= AVS_WRITEDATA[7:0];
         end
      end
   end

   // one wait state per access keeps read data registered
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ack             <= 1'b0;
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         ack             <= (AVS_READ || AVS_WRITE) && !ack;
         AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack);
      end
   end

   // read mux; unmapped addresses read zero
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         AVS_READDATA <= 32'h00000000;
      end else if (AVS_READ && !ack) begin
         if (AVS_ADDRESS == IDX_A1_RATIO) begin
            AVS_READDATA <= {24'h000000, a1_ratio};
         end else if (AVS_ADDRESS == IDX_A_PHASE) begin
            AVS_READDATA <= {24'h000000, a_phase};
         end else if (AVS_ADDRESS == IDX_A2_RATIO) begin
            AVS_READDATA <= {24'h000000, a2_ratio};
         end else if (AVS_ADDRESS == IDX_A_START) begin
            AVS_READDATA <= {24'h000000, a_start};
         end else if (AVS_ADDRESS == IDX_A_DCC) begin
            AVS_READDATA <= {24'h000000, a_dcc};
         end else if (AVS_ADDRESS == IDX_B1_RATIO) begin
            AVS_READDATA <= {24'h000000, b1_ratio};
         end else if (AVS_ADDRESS == IDX_B_PHASE) begin
            AVS_READDATA <= {24'h000000, b_phase};
         end else if (AVS_ADDRESS == IDX_B2_RATIO) begin
            AVS_READDATA <= {24'h000000, b2_ratio};
         end else if (AVS_ADDRESS == IDX_B_START) begin
            AVS_READDATA <= {24'h000000, b_start};
         end else if (AVS_ADDRESS == IDX_B_DCC) begin
            AVS_READDATA <= {24'h000000, b_dcc};
         end else if (AVS_ADDRESS == IDX_CTRL) begin
            AVS_READDATA <= {24'h000000, ctrl};
         end else if (AVS_ADDRESS == IDX_STATUS) begin
            AVS_READDATA <= {28'h0000000, b2_lvl, b1_lvl, a2_lvl, a1_lvl};
         end else begin
            AVS_READDATA <= 32'h00000000;
         end
      end
   end

   // field mapping: counts, start-high, offsets, bypass, correction
   assign cfg_a1 = '{low_count: a1_ratio[LOW_MSB:LOW_LSB], high_count: a1_ratio[HIGH_MSB:HIGH_LSB], // [RULE_11]
                     initial_level_bit: a_start[START1_BIT], coarse_delay_field: a_phase[3:0], // [RULE_10]
                     bypass: a_start[BYP1_BIT], duty_correction_disable: a_dcc[DCC_DISABLE_BIT]};
   assign cfg_a2 = '{low_count: a2_ratio[LOW_MSB:LOW_LSB], high_count: a2_ratio[HIGH_MSB:HIGH_LSB],
                     initial_level_bit: a_start[START2_BIT], coarse_delay_field: a_phase[7:4], // [RULE_10]
                     bypass: a_start[BYP2_BIT], duty_correction_disable: a_dcc[DCC_DISABLE_BIT]};
   assign cfg_b1 = '{low_count: b1_ratio[LOW_MSB:LOW_LSB], high_count: b1_ratio[HIGH_MSB:HIGH_LSB],
                     initial_level_bit: b_start[START1_BIT], coarse_delay_field: b_phase[3:0], // [RULE_09]
                     bypass: b_start[BYP1_BIT], duty_correction_disable: b_dcc[DCC_DISABLE_BIT]};
   assign cfg_b2 = '{low_count: b2_ratio[LOW_MSB:LOW_LSB], high_count: b2_ratio[HIGH_MSB:HIGH_LSB],
                     initial_level_bit: b_start[START2_BIT], coarse_delay_field: b_phase[7:4], // [RULE_09]
                     bypass: b_start[BYP2_BIT], duty_correction_disable: b_dcc[DCC_DISABLE_BIT]};

   // second stage ticks on first stage's rising output
   assign a2_tick = a1_edge && a1_lvl; // [RULE_19]
   assign b2_tick = b1_edge && b1_lvl; // [RULE_19]

   // first divider, stage one
   cdd_stage u_a1 (
      .MCLK      (MCLK),
      .RST       (RST),
      .run       (ctrl[CTRL_RUN_BIT]),
      .clk_en_in (in_tick),
      .level_in  (clk_s2),
      .cfg       (cfg_a1),
      .level_out (a1_lvl),
      .edge_out  (a1_edge)
   );
   // first divider, stage two
   cdd_stage u_a2 (
      .MCLK      (MCLK),
      .RST       (RST),
      .run       (ctrl[CTRL_RUN_BIT]),
      .clk_en_in (a2_tick),
      .level_in  (a1_lvl),
      .cfg       (cfg_a2),
      .level_out (a2_lvl),
      .edge_out  (a2_edge)
   );
   // second divider, stage one
   cdd_stage u_b1 (
      .MCLK      (MCLK),
      .RST       (RST),
      .run       (ctrl[CTRL_RUN_BIT]),
      .clk_en_in (in_tick),
      .level_in  (clk_s2),
      .cfg       (cfg_b1),
      .level_out (b1_lvl),
      .edge_out  (b1_edge)
   );
   // second divider, stage two
   cdd_stage u_b2 (
      .MCLK      (MCLK),
      .RST       (RST),
      .run       (ctrl[CTRL_RUN_BIT]),
      .clk_en_in (b2_tick),
      .level_in  (b1_lvl),
      .cfg       (cfg_b2),
      .level_out (b2_lvl),
      .edge_out  (b2_edge)
   );

   // registered channel outputs; both-bypass passes input duty [RULE_06] [RULE_01] [RULE_02]
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         DIFFERENTIAL_OUTPUT_FIRST <= 1'b0;
         DIFFERENTIAL_OUTPUT_LAST  <= 1'b0;
      end else begin
         DIFFERENTIAL_OUTPUT_FIRST <= a2_lvl; // [RULE_18]
         DIFFERENTIAL_OUTPUT_LAST  <= b2_lvl; // [RULE_04] [RULE_05] [RULE_07]
      end
   end
endmodule : cdd_channel

// ---- sim/cdd_channel_properties.sv ----
// cdd_channel_props: bus handshake and output level checks
`timescale 1ns/1ps
module cdd_channel_props
   import cdd_pkg::*;
(
   // clock and reset
   input wire logic        MCLK,
   input wire logic        RST,
   // register bus
   input wire logic [9:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   // divider outputs
   input wire logic        DIFFERENTIAL_OUTPUT_FIRST,
   input wire logic        DIFFERENTIAL_OUTPUT_LAST
);
   logic run_q;
   wire  req    = AVS_READ | AVS_WRITE;
   wire  mapped = AVS_ADDRESS inside {[IDX_A1_RATIO:IDX_B_DCC], IDX_CTRL, IDX_STATUS};
   // shadow of the run bit, taken on the edge the write is accepted
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         run_q <= 1'b0;
      end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == IDX_CTRL) begin
         run_q <= AVS_WRITEDATA[CTRL_RUN_BIT];
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   wait_idle_a: assert property (!req |=> AVS_WAITREQUEST)
      else $error("waitrequest low without request");
   ack_follow_a: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("request not answered");
   ack_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low too long");
   read_upper_a: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000)
      else $error("read data upper bits set");
   unmapped_zero_a: assert property (AVS_READ && AVS_WAITREQUEST && !mapped |=> AVS_READDATA == 32'h00000000)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
      else $error("read data moved without read");
   held_low_a: assert property (!run_q && !$past(run_q) && !$past(run_q, 2) && !$past(run_q, 3)
      |-> !DIFFERENTIAL_OUTPUT_FIRST && !DIFFERENTIAL_OUTPUT_LAST) else $error("output active while stopped");
   out_min_high_a: assert property ($rose(DIFFERENTIAL_OUTPUT_FIRST) && run_q |=> DIFFERENTIAL_OUTPUT_FIRST)
      else $error("first output high for one clock");
   out_min_low_a: assert property ($fell(DIFFERENTIAL_OUTPUT_LAST) |=> !DIFFERENTIAL_OUTPUT_LAST)
      else $error("last output low for one clock");
endmodule : cdd_channel_props

// ---- sim/tb_cdd_channel.sv ----
// tb_cdd_channel: register and divider output tests
`timescale 1ns/1ps
module tb_cdd_channel
   import cdd_pkg::*;
;
   typedef struct {logic [7:0] r1, r2, st, pb, sb; int hc, per, hi, sk;} cdd_case_t;
   logic        mclk = 1'b0, rst = 1'b1, dclk = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [9:0]  adr = 10'h000;
   logic [31:0] wd = 32'h00000000, rdat;
   logic [3:0]  be = 4'h0;
   logic        wrq, out_a, out_b;
   int          failures = 0, total_checks = 0, hi_c = 4, dcnt = 0;
   logic [9:0]  regs[8] = '{IDX_A1_RATIO, IDX_A_PHASE, IDX_A2_RATIO, IDX_A_START,
                            IDX_B1_RATIO, IDX_B_PHASE, IDX_B2_RATIO, IDX_B_START};
   // ratio1, ratio2, start A, phase B, start-high B, input high, period, high, skew (clocks)
   // the last case repeats an odd ratio with duty correction disabled
   cdd_case_t   cases[12] = '{'{8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 2, 8, 2, 0},
      '{8'h11, 8'h00, 8'h20, 8'h00, 8'h00, 2, 32, 16, 0}, '{8'h21, 8'h00, 8'h20, 8'h00, 8'h00, 4, 40, 20, 0},
      '{8'h21, 8'h00, 8'h20, 8'h00, 8'h00, 2, 40, 18, 0}, '{8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 2, 64, 32, 0},
      '{8'h21, 8'h10, 8'h00, 8'h00, 8'h00, 2, 120, 58, 0}, '{8'h22, 8'h00, 8'h20, 8'h03, 8'h00, 4, 48, 24, 24},
      '{8'h22, 8'h00, 8'h20, 8'h01, 8'h01, 4, 48, 24, 32}, '{8'h00, 8'h11, 8'h00, 8'h10, 8'h00, 4, 64, 32, 16},
      '{8'h00, 8'h11, 8'h00, 8'h00, 8'h02, 4, 64, 32, 32}, '{8'h00, 8'h11, 8'h00, 8'h00, 8'h03, 4, 64, 32, 40},
      '{8'h21, 8'h00, 8'h20, 8'h00, 8'h00, 4, 40, 16, 0}};
   cdd_channel dut_u (.MCLK(mclk), .RST(rst), .DIV_CLK_IN(dclk), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wrq),
      .DIFFERENTIAL_OUTPUT_FIRST(out_a), .DIFFERENTIAL_OUTPUT_LAST(out_b));
   // 100 MHz system clock
   always #5 mclk = ~mclk;
   // divider input: 8 clocks a period, high for hi_c of them, kept slow for the synchroniser
   always @(posedge mclk) begin
      if (dcnt >= (dclk ? hi_c : 8 - hi_c) - 1) begin
         dclk <= ~dclk;
         dcnt <= 0;
      end else begin
         dcnt <= dcnt + 1;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // one access, request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] b,
                      output logic [31:0] q);
      adr <= a;
      wd <= {24'h000000, d};
      be <= b;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge mclk);
      end while (wrq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic wr8(input logic [9:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'h1, q);
   endtask : wr8
   // rise times of both outputs; figures from the second full period
   task automatic meas(input int win, output int per, output int hi, output int sk);
      int   ra[$];
      int   rb[$];
      bit   hs[$];
      logic pa = 1'b1, pb = 1'b1;
      for (int c = 0; c < win; c++) begin
         @(posedge mclk);
         #1;
         if (out_a === 1'b1 && pa !== 1'b1) ra.push_back(c);
         if (out_b === 1'b1 && pb !== 1'b1) rb.push_back(c);
         hs.push_back(out_a === 1'b1);
         pa = out_a;
         pb = out_b;
      end
      @(posedge mclk);
      per = -1;
      hi = 0;
      sk = -1;
      if (ra.size() > 2) begin
         per = ra[2] - ra[1];
         for (int i = ra[1]; i < ra[2]; i++) hi += hs[i];
         foreach (rb[j]) if (sk < 0 && rb[j] >= ra[1]) sk = rb[j] - ra[1];
      end
   endtask : meas
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   // watchdog well beyond twelve cases of a few hundred clocks
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      final_report();
   end
   // main sequence
   initial begin
      logic [31:0] q;
      logic [7:0]  pat;
      cdd_case_t   c;
      int          per, hi, sk;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      foreach (regs[i]) begin
         pat = (regs[i] == IDX_A_START || regs[i] == IDX_B_START) ? 8'h33 : 8'hC5;
         bus(1'b0, regs[i], 8'h00, 4'h1, q);
         check("reset value", q, 32'h00000000);
         bus(1'b1, regs[i], 8'hFF, 4'h0, q);
         bus(1'b1, regs[i], pat, 4'h1, q);
         bus(1'b0, regs[i], 8'h00, 4'h1, q);
         check("read back", q, {24'h000000, pat});
      end
      bus(1'b1, 10'h1C0, 8'h5A, 4'h1, q);
      bus(1'b0, 10'h1C0, 8'h00, 4'h1, q);
      check("unmapped", q, 32'h00000000);
      $display("register test done");
      foreach (cases[i]) begin
         c = cases[i];
         hi_c = c.hc;
         wr8(IDX_CTRL, 8'h00);
         wr8(IDX_A1_RATIO, c.r1);
         wr8(IDX_B1_RATIO, c.r1);
         wr8(IDX_A2_RATIO, c.r2);
         wr8(IDX_B2_RATIO, c.r2);
         wr8(IDX_A_START, c.st);
         wr8(IDX_B_START, c.st | c.sb);
         wr8(IDX_A_PHASE, 8'h00);
         wr8(IDX_B_PHASE, c.pb);
         wr8(IDX_A_DCC, (i == 11) ? 8'h01 : 8'h00);
         wr8(IDX_B_DCC, (i == 11) ? 8'h01 : 8'h00);
         wr8(IDX_CTRL, 8'h01);
         meas(4 * c.per + 60, per, hi, sk);
         check("period", per, c.per);
         check("high time", hi, c.hi);
         check("skew", sk, c.sk);
         $display("case %0d done", i);
      end
      final_report();
   end
endmodule : tb_cdd_channel
bind cdd_channel cdd_channel_props chk_u (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .DIFFERENTIAL_OUTPUT_FIRST(DIFFERENTIAL_OUTPUT_FIRST), .DIFFERENTIAL_OUTPUT_LAST(DIFFERENTIAL_OUTPUT_LAST));
